/* hdl/aar_apb_slave.sv */
// APB address decode and handshake for the register bank
`timescale 1ns/1ps
`default_nettype none
module aar_apb_slave
    import aar_pkg::*;
(
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AAR_ADDR_W-1:0] paddr,
    output logic pready,
    output logic pslverr,
    output logic setup_rd,
    output logic wr_take,
    output logic rd_take,
    output logic [AAR_NREG-1:0] hit
);
    logic aligned;
    logic any_hit;

    assign aligned = (paddr[1:0] == 2'h0);

    // ***********************************************
    // One-hot decode over the index table
    // ***********************************************
    genvar i;
    generate
        for (i = 0; i < AAR_NREG; i++) begin : g_hit
            assign hit[i] = aligned && (paddr[AAR_ADDR_W-1:2] == AAR_IDX_TAB[i]);
        end
    endgenerate

    assign any_hit = |hit;
    // Zero wait states: data was staged in the setup cycle
    assign pready = psel & penable;
    assign pslverr = pready & ~any_hit;
    assign setup_rd = psel & ~penable & ~pwrite;
    assign wr_take = pready & pwrite & any_hit;
    assign rd_take = pready & ~pwrite & any_hit;
endmodule : aar_apb_slave
`default_nettype wire

/* hdl/aar_latch_flag.sv */
// Latching-high flag: set wins over clear
`timescale 1ns/1ps
`default_nettype none
module aar_latch_flag (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic set,
    input wire logic clr,
    input wire logic soft_clr,
    output logic q
);
    logic q_d;

    // Event in the clearing cycle survives
    assign q_d = set | (q & ~clr & ~soft_clr);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= 1'b0;
        end else begin
            q <= q_d;
        end
    end
endmodule : aar_latch_flag
`default_nettype wire

/* hdl/aar_pkg.sv */
// Constants shared by the auto-negotiation ability register bank
package aar_pkg;

    // ***********************************************
    // Bus geometry
    // ***********************************************
    localparam int unsigned AAR_DATA_W = 32;
    localparam int unsigned AAR_ADDR_W = 8;
    localparam int unsigned AAR_REG_W = 16;
    localparam int unsigned AAR_IDX_W = 6;
    localparam int unsigned AAR_NREG = 5;

    // ***********************************************
    // Register indices; byte address is four times the index
    // ***********************************************
    localparam logic [5:0] AAR_IDX_CTRL = 6'h00;
    localparam logic [5:0] AAR_IDX_STAT = 6'h01;
    localparam logic [5:0] AAR_IDX_ADV = 6'h04;
    localparam logic [5:0] AAR_IDX_PARTNER = 6'h05;
    localparam logic [5:0] AAR_IDX_EXP = 6'h06;
    localparam logic [5:0] AAR_IDX_TAB [0:4] = '{6'h00, 6'h01, 6'h04, 6'h05, 6'h06};

    // Positions in the one-hot hit vector, same order as the table
    localparam int unsigned AAR_H_CTRL = 0;
    localparam int unsigned AAR_H_STAT = 1;
    localparam int unsigned AAR_H_ADV = 2;
    localparam int unsigned AAR_H_PARTNER = 3;
    localparam int unsigned AAR_H_EXP = 4;

    // ***********************************************
    // Field positions
    // ***********************************************
    localparam int unsigned AAR_CTRL_SRST_BIT = 15;
    localparam int unsigned AAR_CTRL_RESTART_BIT = 9;
    localparam int unsigned AAR_STAT_DONE_BIT = 5;
    localparam int unsigned AAR_ADV_RF_BIT = 13;
    localparam int unsigned AAR_ADV_PAUSE_LSB = 10;
    localparam int unsigned AAR_PTR_NP_BIT = 15;
    localparam int unsigned AAR_EXP_PDF_BIT = 4;
    localparam int unsigned AAR_EXP_LPNP_BIT = 3;
    localparam int unsigned AAR_EXP_NPA_BIT = 2;
    localparam int unsigned AAR_EXP_PR_BIT = 1;
    localparam int unsigned AAR_EXP_LPAN_BIT = 0;

    // ***********************************************
    // Reset values and masks
    // ***********************************************
    localparam logic [15:0] AAR_ADV_RST = 16'h0c01;
    localparam logic [15:0] AAR_ADV_SEL = 16'h0001;
    localparam logic [15:0] AAR_ADV_WR_MASK = 16'hffe0;
    localparam logic [15:0] AAR_ADV_KEEP_MASK = 16'h3c00;
    localparam logic [15:0] AAR_PTR_MASK = 16'hec1f;
    localparam logic [15:0] AAR_PTR_RST = 16'h0000;
    localparam logic [15:0] AAR_ZERO16 = 16'h0000;
    localparam logic AAR_NPA_VAL = 1'b1;

endpackage : aar_pkg

/* hdl/aar_regs.sv */
// Auto-negotiation ability, partner and expansion registers with APB access
//
// How it works
// - Remote fault bit: writable, hard reset clears
// - Pause field: reset 11, kept over soft reset
// - New advertisement used only after restart or link loss
// - Selector field reads 00001, read-only
// - Partner next page bit, read-only, resets 0
// - Partner acknowledge bit, read-only
// - Partner remote fault bit, read-only
// - Partner pause and selector reset to zero
// - Expansion valid only after negotiation completes; the bank shows its contents as is before completion too
// - Parallel detection fault bit, read-only
// - Partner next page able bit, read-only
// - Local next page able reads 1
// - Page received latches high until read
// - Partner auto-negotiation able bit, read-only
// - Restart bit self-clears when restart taken
// - Status bit 5 shows negotiation complete
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module aar_regs
    import aar_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AAR_ADDR_W-1:0] paddr,
    input wire logic [AAR_DATA_W-1:0] pwdata,
    output logic [AAR_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic base_page_valid,
    input wire logic [AAR_REG_W-1:0] base_page_word,
    input wire logic new_page,
    input wire logic an_complete,
    input wire logic link_down,
    input wire logic restart_taken,
    input wire logic parallel_fault,
    input wire logic partner_an_able,
    output logic [AAR_REG_W-1:0] adv_word,
    output logic restart_req,
    output logic soft_reset
);

    // ***********************************************
    // Bus decode
    // ***********************************************
    logic setup_rd;
    logic wr_take;
    logic rd_take;
    logic [AAR_NREG-1:0] hit;

    aar_apb_slave u_apb (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pready(pready),
        .pslverr(pslverr),
        .setup_rd(setup_rd),
        .wr_take(wr_take),
        .rd_take(rd_take),
        .hit(hit)
    );

    logic hit_ctrl;
    logic hit_stat;
    logic hit_adv;
    logic hit_ptr;
    logic hit_exp;

    // Named hits keep the read mux and the write strobes short
    assign hit_ctrl = hit[AAR_H_CTRL];
    assign hit_stat = hit[AAR_H_STAT];
    assign hit_adv = hit[AAR_H_ADV];
    assign hit_ptr = hit[AAR_H_PARTNER];
    assign hit_exp = hit[AAR_H_EXP];

    logic wr_ctrl;
    logic wr_adv;
    logic rd_exp;

    // Status, partner and expansion ignore writes without an error
    assign wr_ctrl = wr_take & hit_ctrl;
    assign wr_adv = wr_take & hit_adv;
    assign rd_exp = rd_take & hit_exp;

    // ***********************************************
    // Control: software reset and restart
    // ***********************************************
    logic srst_q;
    logic srst_d;
    logic restart_q;
    logic restart_d;
    logic restart_set;
    logic restart_clr;

    logic wr_srst_bit;
    logic wr_restart_bit;

    assign wr_srst_bit = pwdata[AAR_CTRL_SRST_BIT];
    assign wr_restart_bit = pwdata[AAR_CTRL_RESTART_BIT];

    // Soft reset lasts one cycle; the bit itself always reads 0
    assign srst_d = wr_ctrl & wr_srst_bit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            srst_q <= 1'b0;
        end else begin
            srst_q <= srst_d;
        end
    end

    assign restart_set = wr_ctrl & wr_restart_bit;
    // A fresh request beats the acknowledge of the old one
    assign restart_clr = restart_taken | srst_q;
    assign restart_d = restart_set | (restart_q & ~restart_clr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart_q <= 1'b0;
        end else begin
            restart_q <= restart_d;
        end
    end

    assign restart_req = restart_q;
    assign soft_reset = srst_q;

    // ***********************************************
    // Local advertisement
    // ***********************************************
    logic [AAR_REG_W-1:0] adv_q;
    logic [AAR_REG_W-1:0] adv_d;
    logic [AAR_REG_W-1:0] adv_wr_val;
    logic [AAR_REG_W-1:0] adv_soft_val;
    logic [AAR_REG_W-1:0] adv_rd;

    // Bits 15:14 are stored as written; keeping them is up to software
    assign adv_wr_val = pwdata[AAR_REG_W-1:0] & AAR_ADV_WR_MASK;
    // Soft reset keeps remote fault, bit 12 and pause, zeroes the rest
    assign adv_soft_val = adv_q & AAR_ADV_KEEP_MASK;
    assign adv_d = wr_adv ? adv_wr_val : (srst_q ? adv_soft_val : adv_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adv_q <= AAR_ADV_RST & AAR_ADV_WR_MASK;
        end else begin
            adv_q <= adv_d;
        end
    end

    // Selector is a constant, not storage
    assign adv_rd = adv_q | AAR_ADV_SEL;

    // ***********************************************
    // Advertisement seen by the negotiation engine
    // ***********************************************
    logic [AAR_REG_W-1:0] adv_act_q;
    logic [AAR_REG_W-1:0] adv_act_d;
    logic adv_reload;

    // Writes stay invisible to the partner until a restart or link loss
    assign adv_reload = restart_taken | link_down;
    assign adv_act_d = adv_reload ? adv_rd : adv_act_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adv_act_q <= AAR_ADV_RST;
        end else begin
            adv_act_q <= adv_act_d;
        end
    end

    assign adv_word = adv_act_q;

    // ***********************************************
    // Partner ability
    // ***********************************************
    logic [AAR_REG_W-1:0] ptr_q;
    logic [AAR_REG_W-1:0] ptr_d;
    logic [AAR_REG_W-1:0] ptr_cap;

    // Only next page, ack, fault, pause and selector are kept
    assign ptr_cap = base_page_word & AAR_PTR_MASK;
    logic ptr_load;

    // Soft reset wins over a page arriving in the same cycle
    assign ptr_load = base_page_valid & ~srst_q;
    assign ptr_d = srst_q ? AAR_PTR_RST : (ptr_load ? ptr_cap : ptr_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_q <= AAR_PTR_RST;
        end else begin
            ptr_q <= ptr_d;
        end
    end

    // ***********************************************
    // Read word helpers
    // ***********************************************
    // One flag placed in an otherwise zero register word
    function automatic logic [AAR_REG_W-1:0] aar_flag_word(
        input int unsigned pos,
        input logic val
    );
        logic [AAR_REG_W-1:0] word;
        word = AAR_ZERO16;
        word[pos] = val;
        return word;
    endfunction : aar_flag_word

    // Unselected registers give zero, so the read mux is a plain OR
    function automatic logic [AAR_REG_W-1:0] aar_pick(
        input logic sel,
        input logic [AAR_REG_W-1:0] word
    );
        return sel ? word : AAR_ZERO16;
    endfunction : aar_pick

    // ***********************************************
    // Expansion
    // ***********************************************
    logic page_flag;
    logic page_clr;
    logic [AAR_REG_W-1:0] exp_rd;
    logic [AAR_DATA_W-1:0] prdata_q;
    logic [AAR_DATA_W-1:0] prdata_d;

    // Clear only what the staged read showed, so a late page is kept
    assign page_clr = rd_exp & prdata_q[AAR_EXP_PR_BIT];

    aar_latch_flag u_page_flag (
        .clk(pclk),
        .rst_n(presetn),
        .set(new_page),
        .clr(page_clr),
        .soft_clr(srst_q),
        .q(page_flag)
    );

    logic exp_pdf;
    logic exp_lpnp;
    logic exp_npa;
    logic exp_pr;
    logic exp_lpan;

    // Only the page flag is stored here; next page able comes from the partner register, the rest are live or fixed
    assign exp_pdf = parallel_fault;
    assign exp_lpnp = ptr_q[AAR_PTR_NP_BIT];
    assign exp_npa = AAR_NPA_VAL;
    assign exp_pr = page_flag;
    assign exp_lpan = partner_an_able;

    // Contents are shown as is even before completion
    assign exp_rd = aar_flag_word(AAR_EXP_PDF_BIT, exp_pdf)
                  | aar_flag_word(AAR_EXP_LPNP_BIT, exp_lpnp)
                  | aar_flag_word(AAR_EXP_NPA_BIT, exp_npa)
                  | aar_flag_word(AAR_EXP_PR_BIT, exp_pr)
                  | aar_flag_word(AAR_EXP_LPAN_BIT, exp_lpan);

    // ***********************************************
    // Control and status read words
    // ***********************************************
    logic [AAR_REG_W-1:0] ctrl_rd;
    logic [AAR_REG_W-1:0] stat_rd;

    // Restart reads as pending until the engine takes it
    assign ctrl_rd = aar_flag_word(AAR_CTRL_RESTART_BIT, restart_q);
    // Completion follows the engine directly, nothing is latched
    assign stat_rd = aar_flag_word(AAR_STAT_DONE_BIT, an_complete);

    // ***********************************************
    // Read data, staged in the setup cycle
    // ***********************************************
    logic [AAR_REG_W-1:0] rd_word;

    // Unmapped addresses read zero and flag an error
    assign rd_word = aar_pick(hit_ctrl, ctrl_rd)
                   | aar_pick(hit_stat, stat_rd)
                   | aar_pick(hit_adv, adv_rd)
                   | aar_pick(hit_ptr, ptr_q)
                   | aar_pick(hit_exp, exp_rd);

    assign prdata_d = setup_rd ? {AAR_ZERO16, rd_word} : prdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= {AAR_ZERO16, AAR_ZERO16};
        end else begin
            prdata_q <= prdata_d;
        end
    end

    assign prdata = prdata_q;

endmodule : aar_regs
`default_nettype wire

/* verification/aar_partner_model.sv */
// Negotiation engine and link partner model
`timescale 1ns/1ps
`default_nettype none
module aar_partner_model (
    input wire logic pclk,
    input wire logic restart_req,
    input wire logic [7:0] dly,
    input wire logic [15:0] page,
    input wire logic pf,
    input wire logic able,
    output logic restart_taken,
    output logic base_page_valid,
    output logic [15:0] base_page_word,
    output logic new_page,
    output logic an_complete,
    output logic parallel_fault,
    output logic partner_an_able
);
    initial begin
        {restart_taken, base_page_valid, new_page, an_complete} = 4'h0;
        {parallel_fault, partner_an_able} = 2'b00;
        base_page_word = 16'h0;
        forever begin
            @(posedge pclk);
            if (restart_req) begin
                // Slow or prompt take of the restart
                repeat (dly) @(posedge pclk);
                restart_taken <= 1'b1;
                an_complete <= 1'b0;
                @(posedge pclk);
                restart_taken <= 1'b0;
                repeat (3) @(posedge pclk);
                base_page_valid <= 1'b1;
                new_page <= 1'b1;
                base_page_word <= page;
                an_complete <= 1'b1;
                parallel_fault <= pf;
                partner_an_able <= able;
                @(posedge pclk);
                {base_page_valid, new_page} <= 2'b00;
                // Released word must not look valid
                base_page_word <= ~page;
            end
        end
    end
endmodule : aar_partner_model
`default_nettype wire

/* verification/aar_regs_chk.sv */
// Port-level assertions for the ability register bank
`timescale 1ns/1ps
`default_nettype none
module aar_regs_chk
    import aar_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AAR_ADDR_W-1:0] paddr,
    input wire logic [AAR_DATA_W-1:0] pwdata,
    input wire logic [AAR_DATA_W-1:0] prdata,
    input wire logic link_down,
    input wire logic restart_taken,
    input wire logic parallel_fault,
    input wire logic partner_an_able,
    input wire logic an_complete,
    input wire logic [AAR_REG_W-1:0] adv_word,
    input wire logic restart_req,
    input wire logic soft_reset
);
    // ***********************************************
    // Access decode
    // ***********************************************
    wire rd = psel && penable && !pwrite;
    wire wr_ctl = psel && penable && pwrite && paddr == 8'h00;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_restart_set: assert property (wr_ctl && pwdata[9] |=> restart_req)
        else $error("restart request not raised");
    a_restart_clear: assert property (restart_req && restart_taken
        && !(wr_ctl && pwdata[9]) |=> !restart_req)
        else $error("restart request not cleared");
    a_advert_hold: assert property (!restart_taken && !link_down |=> $stable(adv_word))
        else $error("advertisement in use changed early");
    a_sel_fixed: assert property (adv_word[4:0] == 5'h01)
        else $error("selector in use wrong");
    a_done_shown: assert property (rd && paddr == 8'h04 |-> prdata[5] == $past(an_complete))
        else $error("completion bit wrong");
    a_exp_const: assert property (rd && paddr == 8'h18 |-> prdata[2] && prdata[31:5] == 27'h0)
        else $error("expansion constant bits wrong");
    a_exp_live: assert property (rd && paddr == 8'h18 |-> prdata[4] == $past(parallel_fault)
        && prdata[0] == $past(partner_an_able))
        else $error("expansion live bits wrong");
    a_ptr_rsvd: assert property (rd && paddr == 8'h14 |-> prdata[12] == 1'b0
        && prdata[9:5] == 5'h00 && prdata[31:16] == 16'h0)
        else $error("partner reserved bits set");
    a_soft_pulse: assert property (wr_ctl && pwdata[15] |=> soft_reset ##1 !soft_reset)
        else $error("soft reset pulse wrong");
endmodule : aar_regs_chk
`default_nettype wire

/* verification/tb_autoneg_ability_registers.sv */
// Self-checking bench for the ability register bank
`timescale 1ns/1ps
`default_nettype none
module tb_autoneg_ability_registers import aar_pkg::*;;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ld = 0;
    logic [7:0] paddr = 0, dly = 0;
    logic [31:0] pwdata = 0, prdata;
    logic pready, pslverr, bpv, np, anc, rt, pfo, ableo, rreq, srst, pf = 0, able = 0, pfv, abv;
    logic [15:0] bpw, adv_word, page = 0, w, adv_exp, pg;
    logic [31:0] q[$];
    int errors = 0, compares = 0, i, n;
    always #2.5 pclk = ~pclk;
    aar_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .base_page_valid(bpv), .base_page_word(bpw), .new_page(np),
        .an_complete(anc), .link_down(ld), .restart_taken(rt), .parallel_fault(pfo),
        .partner_an_able(ableo), .adv_word(adv_word), .restart_req(rreq), .soft_reset(srst));
    aar_partner_model u_far (.pclk(pclk), .restart_req(rreq), .dly(dly), .page(page),
        .pf(pf), .able(able), .restart_taken(rt), .base_page_valid(bpv),
        .base_page_word(bpw), .new_page(np), .an_complete(anc), .parallel_fault(pfo),
        .partner_an_able(ableo));
    // ***********************************************
    // Checking and bus tasks
    // ***********************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task wrap_up;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up
    // Reads carry their expected word in d
    always @(posedge pclk) if (psel && penable && !pwrite) begin
        if (q.size() == 0) chk(32'h1, 32'h0);
        else chk(prdata, q.pop_front());
    end
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        logic bad;
        // Unaligned or unmapped addresses must answer with an error
        bad = (a[1:0] != 2'h0) || (a[7:2] > AAR_IDX_EXP)
            || (a[7:2] > AAR_IDX_STAT && a[7:2] < AAR_IDX_ADV);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr) q.push_back(d);
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin errors++; wrap_up; end
        chk({31'h0, pslverr}, {31'h0, bad});
        psel <= 0;
        penable <= 0;
    endtask : apb
    // ***********************************************
    // Scenarios
    // ***********************************************
    initial begin
        void'($urandom(32'he26d570c));
        repeat (16) @(posedge pclk);
        presetn <= 1;
        apb(1, 8'h11, 32'h2000);
        apb(0, 8'h10, 32'h0c01);
        apb(0, 8'h14, 32'h0);
        apb(0, 8'h18, 32'h4);
        apb(0, 8'h04, 32'h0);
        apb(0, 8'h08, 32'h0);
        for (i = 0; i < 4; i++) begin
            w = {2'b00, i[0], i[1], i[1:0], 10'h01e};
            apb(1, 8'h10, {16'h0, w});
            apb(0, 8'h10, {16'h0, (w & AAR_ADV_WR_MASK) | AAR_ADV_SEL});
            chk({16'h0, adv_word}, 32'h0c01);
        end
        for (i = 0; i < 2; i++) begin
            pg = 16'($urandom);
            pfv = 1'($urandom);
            abv = 1'($urandom);
            page <= pg;
            pf <= pfv;
            able <= abv;
            dly <= i ? 8'd20 : 8'd0;
            w = 16'($urandom) & 16'h3c00;
            adv_exp = w | AAR_ADV_SEL;
            apb(1, 8'h10, {16'h0, w});
            apb(1, 8'h00, 32'h0200);
            if (i) begin @(posedge pclk); apb(0, 8'h00, 32'h0200); end
            n = 0;
            while (bpv !== 1'b1 && n < 200) begin @(posedge pclk); n++; end
            if (n >= 200) begin errors++; wrap_up; end
            repeat (2) @(posedge pclk);
            chk({16'h0, adv_word}, {16'h0, adv_exp});
            apb(0, 8'h00, 32'h0);
            apb(0, 8'h04, 32'h20);
            apb(0, 8'h14, {16'h0, pg & AAR_PTR_MASK});
            apb(0, 8'h18, {27'h0, pfv, pg[15], 2'b11, abv});
            apb(0, 8'h18, {27'h0, pfv, pg[15], 2'b10, abv});
        end
        w = ~adv_exp & 16'h3c00;
        apb(1, 8'h10, {16'h0, w});
        chk({16'h0, adv_word}, {16'h0, adv_exp});
        @(posedge pclk) ld <= 1;
        @(posedge pclk) ld <= 0;
        @(posedge pclk);
        chk({16'h0, adv_word}, {16'h0, w | AAR_ADV_SEL});
        apb(1, 8'h10, 32'h3fe0);
        apb(1, 8'h00, 32'h8000);
        repeat (2) @(posedge pclk);
        apb(0, 8'h10, 32'h3c01);
        apb(0, 8'h14, 32'h0);
        apb(0, 8'h18, {27'h0, pfv, 3'b010, abv});
        @(posedge pclk) presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        apb(0, 8'h10, 32'h0c01);
        chk({16'h0, adv_word}, 32'h0c01);
        wrap_up;
    end
endmodule : tb_autoneg_ability_registers
bind aar_regs aar_regs_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .link_down(link_down), .restart_taken(restart_taken), .parallel_fault(parallel_fault),
    .partner_an_able(partner_an_able), .an_complete(an_complete), .adv_word(adv_word),
    .restart_req(restart_req), .soft_reset(soft_reset));
`default_nettype wire
